// >>> hw/fifo_port_ready_reporting.sv
`timescale 1ns/1ns
module fifo_port_ready_reporting #(
  parameter int NUM_PORTS = 8
) (
  input wire logic ref_clk, // fifo bus clock, 125 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic tx_ctl_n, // pin: transmit ready output enable
  input wire logic rx_ctl_n, // pin: receive ready output enable
  input wire logic header_mode, // report receive-ready on header arrival
  input wire fifo_ready_pkg::tx_port_t [NUM_PORTS-1:0] tx_port, // tx status
  input wire fifo_ready_pkg::rx_port_t [NUM_PORTS-1:0] rx_port, // rx status
  output logic [NUM_PORTS-1:0] tx_rdy_o, // transmit space ready, per port
  output logic [NUM_PORTS-1:0] tx_rdy_oe, // drive enable of tx_rdy_o
  output logic [NUM_PORTS-1:0] rx_rdy_o, // receive data ready, per port
  output logic [NUM_PORTS-1:0] rx_rdy_oe, // drive enable of rx_rdy_o
  output logic [NUM_PORTS-1:0] rx_discard_o // receive discard flag, per port
);

  ////////////////////////////////////////////////////////////////////////////
  // enable pins come from the bus master, so synchronise them first

  logic [1:0] tx_ctl_sync_q;
  logic [1:0] rx_ctl_sync_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ctl_sync_q <= fifo_ready_pkg::SYNC_RST;
    end else begin
      tx_ctl_sync_q <= {tx_ctl_sync_q[0], tx_ctl_n};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ctl_sync_q <= fifo_ready_pkg::SYNC_RST;
    end else begin
      rx_ctl_sync_q <= {rx_ctl_sync_q[0], rx_ctl_n};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks start one edge after reset release: the release edge itself
  // still resets the outputs, so a check launched there sees stale zeros

  logic live_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_q <= fifo_ready_pkg::OUT_RST;
    end else begin
      live_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port ready generation

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    logic stall_q;
    logic tx_rdy_d;
    logic rx_rdy_d;
    logic discard_d;

    // set wins over clear so a stop during the status read is not lost
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        stall_q <= fifo_ready_pkg::STALL_RST;
      end else if (tx_port[i].err_stop) begin
        stall_q <= 1'b1;
      end else if (tx_port[i].err_read) begin
        stall_q <= 1'b0;
      end
    end

    always_comb begin
      tx_rdy_d = (tx_port[i].free_level >= tx_port[i].threshold)
                 && !stall_q && !tx_port[i].err_stop;
      discard_d = rx_port[i].drop && rx_port[i].drop_started;
      rx_rdy_d = (rx_port[i].fill_level >= rx_port[i].threshold)
                 || rx_port[i].eop_written
                 || (header_mode && rx_port[i].header_present)
                 || discard_d;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_rdy_o[i] <= fifo_ready_pkg::OUT_RST;
        rx_rdy_o[i] <= fifo_ready_pkg::OUT_RST;
        rx_discard_o[i] <= fifo_ready_pkg::OUT_RST;
      end else begin
        tx_rdy_o[i] <= tx_rdy_d;
        rx_rdy_o[i] <= rx_rdy_d;
        rx_discard_o[i] <= discard_d;
      end
    end

    // drivers are shared lines; float unless the master enables us
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_rdy_oe[i] <= fifo_ready_pkg::OE_RST;
        rx_rdy_oe[i] <= fifo_ready_pkg::OE_RST;
      end else begin
        tx_rdy_oe[i] <= !tx_ctl_sync_q[1];
        rx_rdy_oe[i] <= !rx_ctl_sync_q[1];
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks

    AST_RX_OE_ON: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      !rx_ctl_n [*4] |-> rx_rdy_oe[i])
      else $error("rx ready not driven while enabled");

    AST_TX_OE_ON: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      !tx_ctl_n [*4] |-> tx_rdy_oe[i])
      else $error("tx ready not driven while enabled");

    AST_OE_OFF: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      (rx_ctl_n && tx_ctl_n) [*4] |-> !rx_rdy_oe[i] && !tx_rdy_oe[i])
      else $error("ready driven while disabled");

    AST_TX_THRESH: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_rdy_o[i] |->
        $past(tx_port[i].free_level >= tx_port[i].threshold))
      else $error("tx ready without enough free space");

    AST_TX_STALL: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_port[i].err_stop ##1 !tx_port[i].err_read [*2] |=> !tx_rdy_o[i])
      else $error("tx ready released before error read");

    AST_RX_THRESH: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_port[i].fill_level >= rx_port[i].threshold |=> rx_rdy_o[i])
      else $error("rx ready missing at threshold");

    AST_RX_EOP: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_port[i].eop_written |=> rx_rdy_o[i])
      else $error("rx ready missing at end of packet");

    AST_RX_HDR: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      header_mode && rx_port[i].header_present |=> rx_rdy_o[i])
      else $error("rx ready missing on header");

    AST_RX_DISCARD: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_port[i].drop && rx_port[i].drop_started
        |=> rx_rdy_o[i] && rx_discard_o[i])
      else $error("discard not reported");

    AST_DISCARD_CAUSE: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_discard_o[i] |->
        $past(rx_port[i].drop) && $past(rx_port[i].drop_started))
      else $error("discard flag without started errored drop");

    AST_TX_OE_OFF: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_ctl_n [*4] |-> !tx_rdy_oe[i])
      else $error("tx ready driven while its enable is off");

    AST_RX_OE_OFF: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_ctl_n [*4] |-> !rx_rdy_oe[i])
      else $error("rx ready driven while its enable is off");

    AST_TX_LOW: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_port[i].free_level < tx_port[i].threshold |=> !tx_rdy_o[i])
      else $error("tx ready with too little free space");

    AST_TX_STOP_NOW: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_port[i].err_stop |=> !tx_rdy_o[i])
      else $error("tx ready right after error stop");

    AST_TX_STOP_NEXT: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      tx_port[i].err_stop ##1 !tx_port[i].err_read |=> !tx_rdy_o[i])
      else $error("tx ready one cycle after error stop");

    // a read in the stop cycle must not clear the new stall
    AST_TX_STOP_WINS: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      (tx_port[i].err_stop && tx_port[i].err_read)
        ##1 !tx_port[i].err_read |=> !tx_rdy_o[i])
      else $error("error read in stop cycle released tx ready");

    AST_TX_RELEASE: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      (tx_port[i].err_read && !tx_port[i].err_stop)
        ##1 (tx_port[i].free_level >= tx_port[i].threshold
             && !tx_port[i].err_stop) |=> tx_rdy_o[i])
      else $error("tx ready not released after error read");

    AST_RX_CAUSE: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_rdy_o[i] |-> $past(
        rx_port[i].fill_level >= rx_port[i].threshold
        || rx_port[i].eop_written
        || (header_mode && rx_port[i].header_present)
        || (rx_port[i].drop && rx_port[i].drop_started)))
      else $error("rx ready with no cause");

    AST_DISCARD_RDY: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_discard_o[i] |-> rx_rdy_o[i])
      else $error("discard flag without rx ready");

    AST_DISCARD_NONE: assert property (
      @(posedge ref_clk) disable iff (!arst_n || !live_q)
      rx_port[i].drop && !rx_port[i].drop_started |=> !rx_discard_o[i])
      else $error("discard flag for packet not yet on the bus");
  end

endmodule : fifo_port_ready_reporting

// >>> pkg/fifo_ready_pkg.sv
package fifo_ready_pkg;

  // fill and free levels are counted in fifo words
  localparam int LEVEL_W = 10;

  // control enables idle high (inactive) until the pin is sampled
  localparam logic [1:0] SYNC_RST = 2'h3;
  localparam logic OUT_RST = 1'h0;
  localparam logic OE_RST = 1'h0;
  localparam logic STALL_RST = 1'h0;

  // per-port status from the transmit fifo
  typedef struct packed {
    logic [LEVEL_W-1:0] free_level; // words free in the transmit fifo
    logic [LEVEL_W-1:0] threshold; // programmed load threshold
    logic err_stop; // pulse: transmission stopped on error
    logic err_read; // pulse: transmit error status was read
  } tx_port_t;

  // per-port status from the receive fifo
  typedef struct packed {
    logic [LEVEL_W-1:0] fill_level; // words stored in the receive fifo
    logic [LEVEL_W-1:0] threshold; // programmed receive threshold
    logic eop_written; // level: end of packet is in the fifo
    logic header_present; // level: packet header is in the fifo
    logic drop; // pulse: errored packet removed from the fifo
    logic drop_started; // level: that packet had begun on the bus
  } rx_port_t;

endpackage : fifo_ready_pkg

// >>> verif/fifo_master_model.sv
`timescale 1ns/1ns
module fifo_master_model #(
  parameter int N = 2
) (
  input wire logic [N-1:0] rdy_o, // value offered by each port
  input wire logic [N-1:0] rdy_oe, // drive enable of each port
  output logic [N-1:0] rdy_line // shared ready line as the master sees it
);
  // board pull-up wins whenever a port leaves its line floating
  assign rdy_line = (rdy_o & rdy_oe) | ~rdy_oe;
endmodule : fifo_master_model

// >>> verif/fifo_port_ready_reporting_tb.sv
`timescale 1ns/1ns
module fifo_port_ready_reporting_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic tx_ctl_n = 1'b1;
  logic rx_ctl_n = 1'b1;
  logic header_mode = 1'b0;
  fifo_ready_pkg::tx_port_t [1:0] tx_port;
  fifo_ready_pkg::rx_port_t [1:0] rx_port;
  logic [1:0] tx_o, tx_oe, rx_o, rx_oe, disc, tx_line, rx_line;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  fifo_port_ready_reporting #(.NUM_PORTS(2)) dut_u (.ref_clk(ref_clk),
    .arst_n(arst_n), .tx_ctl_n(tx_ctl_n), .rx_ctl_n(rx_ctl_n),
    .header_mode(header_mode), .tx_port(tx_port), .rx_port(rx_port),
    .tx_rdy_o(tx_o), .tx_rdy_oe(tx_oe), .rx_rdy_o(rx_o),
    .rx_rdy_oe(rx_oe), .rx_discard_o(disc));
  fifo_master_model #(.N(2)) tx_m (.rdy_o(tx_o), .rdy_oe(tx_oe),
    .rdy_line(tx_line));
  fifo_master_model #(.N(2)) rx_m (.rdy_o(rx_o), .rdy_oe(rx_oe),
    .rdy_line(rx_line));
  initial forever #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // the whole run needs well under 200 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end
  task check(input logic seen, input logic exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task set_tx(input logic [9:0] f, input logic s, input logic r);
    @(posedge ref_clk);
    tx_port[0].free_level <= f;
    tx_port[0].err_stop <= s;
    tx_port[0].err_read <= r;
  endtask : set_tx
  task set_rx(input logic [9:0] f, input logic e, input logic h,
              input logic d, input logic st);
    @(posedge ref_clk);
    rx_port[0].fill_level <= f;
    rx_port[0].eop_written <= e;
    rx_port[0].header_present <= h;
    rx_port[0].drop <= d;
    rx_port[0].drop_started <= st;
  endtask : set_rx
  ////////////////////////////////////////////////////////////////////////////
  task t_enable;
    tick(6);
    check(tx_line[0], 1'b1, "tx line not floating");
    check(rx_line[0], 1'b1, "rx line not floating");
    @(posedge ref_clk);
    tx_ctl_n <= 1'b0;
    rx_ctl_n <= 1'b0;
    tick(6);
    check(&tx_oe, 1'b1, "tx drivers off");
    check(&rx_oe, 1'b1, "rx drivers off");
    check(tx_line[0], 1'b0, "tx status wrong");
    check(rx_line[0], 1'b0, "rx status wrong");
    check(tx_line[1], 1'b1, "tx port 1 status wrong");
    check(rx_line[1], 1'b1, "rx port 1 status wrong");
    $display("t_enable done");
  endtask : t_enable
  task t_tx;
    set_tx(10'h004, 1'b0, 1'b0);
    tick(2);
    check(tx_line[0], 1'b1, "tx low at threshold");
    set_tx(10'h003, 1'b0, 1'b0);
    tick(2);
    check(tx_line[0], 1'b0, "tx high below threshold");
    set_tx(10'h004, 1'b1, 1'b0);
    set_tx(10'h004, 1'b0, 1'b0);
    tick(3);
    check(tx_line[0], 1'b0, "tx ready after error stop");
    set_tx(10'h004, 1'b0, 1'b1);
    set_tx(10'h004, 1'b0, 1'b0);
    tick(2);
    check(tx_line[0], 1'b1, "tx not released");
    set_tx(10'h004, 1'b1, 1'b1);
    set_tx(10'h004, 1'b0, 1'b0);
    tick(3);
    check(tx_line[0], 1'b0, "error read cleared a new stop");
    set_tx(10'h004, 1'b0, 1'b1);
    set_tx(10'h004, 1'b0, 1'b0);
    tick(2);
    check(tx_line[0], 1'b1, "tx not released after read");
    $display("t_tx done");
  endtask : t_tx
  task t_rx;
    set_rx(10'h005, 1'b0, 1'b0, 1'b0, 1'b0);
    tick(2);
    check(rx_line[0], 1'b1, "rx low at threshold");
    set_rx(10'h004, 1'b0, 1'b0, 1'b0, 1'b0);
    tick(2);
    check(rx_line[0], 1'b0, "rx high below threshold");
    set_rx(10'h004, 1'b1, 1'b0, 1'b0, 1'b0);
    tick(2);
    check(rx_line[0], 1'b1, "rx low with end of packet");
    set_rx(10'h004, 1'b0, 1'b1, 1'b0, 1'b0);
    tick(2);
    check(rx_line[0], 1'b0, "rx high on header, option off");
    @(posedge ref_clk);
    header_mode <= 1'b1;
    tick(2);
    check(rx_line[0], 1'b1, "rx low on header, option on");
    @(posedge ref_clk);
    header_mode <= 1'b0;
    set_rx(10'h004, 1'b0, 1'b0, 1'b1, 1'b1);
    set_rx(10'h004, 1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    check(disc[0], 1'b1, "discard missing");
    check(rx_line[0], 1'b1, "rx low on discard");
    tick(1);
    check(disc[0], 1'b0, "discard longer than a cycle");
    check(rx_line[0], 1'b0, "rx ready longer than discard");
    set_rx(10'h004, 1'b0, 1'b0, 1'b1, 1'b0);
    set_rx(10'h004, 1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    check(disc[0], 1'b0, "discard for unstarted packet");
    check(rx_line[0], 1'b0, "rx ready on unstarted drop");
    $display("t_rx done");
  endtask : t_rx
  task t_off;
    set_tx(10'h003, 1'b0, 1'b0);
    tx_ctl_n <= 1'b1;
    tick(5);
    check(|tx_oe, 1'b0, "tx drivers still on");
    check(tx_line[0], 1'b1, "tx line not floating");
    check(&rx_oe, 1'b1, "rx drivers dropped");
    check(rx_line[0], 1'b0, "rx line not driven");
    $display("t_off done");
  endtask : t_off
  initial begin
    tx_port = '0;
    rx_port = '0;
    tx_port[0].threshold = 10'h004;
    rx_port[0].threshold = 10'h005;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_enable();
    t_tx();
    t_rx();
    t_off();
    end_of_test();
  end
endmodule : fifo_port_ready_reporting_tb
